/* logic/mii_port_regs.vh */
// Purpose: Constants for the media-independent port with management pins
// Assumes: System clock 50 MHz
// Notes: Management frame field positions and timing counts
`ifndef MII_PORT_REGS_VH
`define MII_PORT_REGS_VH

`define SYS_CLK_HZ 50000000
`define MDC_HZ 2500000
`define MDC_HALF_CYCLES (`SYS_CLK_HZ / (2 * `MDC_HZ))
`define MGMT_PREAMBLE_BITS 32
`define MGMT_FRAME_BITS 32
`define MGMT_START 2'b01
`define MGMT_OP_WRITE 2'b01
`define MGMT_OP_READ 2'b10
`define MGMT_TA_WRITE 2'b10
`define MGMT_TA_BIT 17
`define PREAMBLE_NIBBLE 4'h5
`define SFD_NIBBLE 4'hd
`define PREAMBLE_NIBBLES 15

`endif

/* logic/mii_port_with_mgmt.v */
// Purpose: One media-independent port and the shared management pins
// Assumes: Transceiver clocks and pins are sampled on SYS_CLK
// Notes: Preamble and start nibbles are inserted ahead of each frame
//
// Function
// - Transmit nibbles change in step with the transmit clock.
// - Frame enable rises with the first preamble nibble and stays until the last nibble.
// - Receive nibbles are sampled in step with the receive clock.
// - Received nibbles count as frame content only while receive-valid is high.
// - Carrier sense is synchronized before use since it rises at any time.
// - One management data line carries write data to both transceivers.
// - Management data launches and samples on the management clock.
// - The management clock pin is an input after reset until software makes it drive.
`timescale 1ns/1ps
`include "mii_port_regs.vh"

module mii_port_with_mgmt (
  input wire SYS_CLK, // System clock
  input wire RESET, // Synchronous reset, active high
  input wire CLK_EN, // Freezes all state when low
  input wire PHY_TX_CLOCK_IN, // Transmit clock from transceiver
  output reg [3:0] TX_NIBBLE_OUT, // Transmit nibble
  output reg TX_FRAME_ENABLE, // Transmit frame enable
  input wire PHY_RX_CLOCK_IN, // Receive clock from transceiver
  input wire [3:0] RX_NIBBLE_IN, // Receive nibble
  input wire RX_VALID_IN, // Receive valid
  input wire COLLISION_IN, // Collision from transceiver
  input wire CARRIER_SENSE_IN, // Carrier sense from transceiver
  input wire [3:0] TX_DATA, // Frame nibble from user
  input wire TX_VALID, // Frame nibble valid
  input wire TX_LAST, // Last nibble of frame
  output wire TX_READY, // Nibble taken this cycle
  output reg [3:0] RX_DATA, // Received frame nibble
  output reg RX_STROBE, // One-cycle strobe for RX_DATA
  output reg RX_END, // Pulse when receive-valid falls
  output reg COLLISION, // Synchronized collision
  output reg CARRIER, // Synchronized carrier sense
  input wire MGMT_CLOCK_DRIVE, // Drive management clock pin
  input wire MGMT_START, // Start management transfer
  input wire MGMT_READ, // Read when high, write when low
  input wire [4:0] MGMT_PHY_ADDR, // Transceiver address
  input wire [4:0] MGMT_REG_ADDR, // Register address
  input wire [15:0] MGMT_WDATA, // Write data
  output reg [15:0] MGMT_RDATA, // Read data
  output wire MGMT_BUSY, // Transfer in progress
  output reg MGMT_DONE, // Pulse at end of transfer
  input wire MGMT_CLOCK_LINE_I, // Management clock pin level
  output reg MGMT_CLOCK_LINE_O, // Management clock drive value
  output reg MGMT_CLOCK_LINE_OE, // Management clock drive enable
  input wire MGMT_DATA_LINE_I, // Management data pin level
  output reg MGMT_DATA_LINE_O, // Management data drive value
  output reg MGMT_DATA_LINE_OE // Management data drive enable
);

  localparam TX_IDLE = 2'd0;
  localparam TX_PRE = 2'd1;
  localparam TX_SFD = 2'd2;
  localparam TX_DATA_ST = 2'd3;
  localparam integer MDC_HALF_COUNT = `MDC_HALF_CYCLES;
  localparam [7:0] MDC_HALF = MDC_HALF_COUNT[7:0];

  // ****************************************
  // Input synchronizers
  // ****************************************
  reg [1:0] txc_s, rxc_s, col_s, crs_s, dv_s, mdi_s, mdc_s;
  reg [3:0] rxd_s1, rxd_s2;
  reg txc_d, rxc_d, mdc_d;
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      txc_s <= 2'b00;
      rxc_s <= 2'b00;
      col_s <= 2'b00;
      crs_s <= 2'b00;
      dv_s <= 2'b00;
      mdi_s <= 2'b11;
      mdc_s <= 2'b00;
      rxd_s1 <= 4'h0;
      rxd_s2 <= 4'h0;
      txc_d <= 1'b0;
      rxc_d <= 1'b0;
      mdc_d <= 1'b0;
    end else if (CLK_EN) begin
      txc_s <= {txc_s[0], PHY_TX_CLOCK_IN};
      rxc_s <= {rxc_s[0], PHY_RX_CLOCK_IN};
      col_s <= {col_s[0], COLLISION_IN};
      crs_s <= {crs_s[0], CARRIER_SENSE_IN};
      dv_s <= {dv_s[0], RX_VALID_IN};
      mdi_s <= {mdi_s[0], MGMT_DATA_LINE_I};
      mdc_s <= {mdc_s[0], MGMT_CLOCK_LINE_I};
      rxd_s1 <= RX_NIBBLE_IN;
      rxd_s2 <= rxd_s1;
      txc_d <= txc_s[1];
      rxc_d <= rxc_s[1];
      mdc_d <= mdc_s[1];
    end
  end

  wire tx_edge = txc_s[1] & ~txc_d;
  wire rx_edge = rxc_s[1] & ~rxc_d;

  // ****************************************
  // Transmit path
  // ****************************************
  reg [1:0] tx_state;
  reg [3:0] pre_cnt;
  assign TX_READY = CLK_EN & tx_edge & (tx_state == TX_DATA_ST) & TX_VALID;
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      tx_state <= TX_IDLE;
      pre_cnt <= 4'h0;
      TX_NIBBLE_OUT <= 4'h0;
      TX_FRAME_ENABLE <= 1'b0;
      COLLISION <= 1'b0;
      CARRIER <= 1'b0;
    end else if (CLK_EN) begin
      COLLISION <= col_s[1];
      CARRIER <= crs_s[1];
      if (tx_edge) begin
        case (tx_state)
          TX_IDLE: begin
            if (TX_VALID) begin
              tx_state <= TX_PRE;
              pre_cnt <= 4'h1;
              TX_NIBBLE_OUT <= `PREAMBLE_NIBBLE;
              TX_FRAME_ENABLE <= 1'b1;
            end else begin
              TX_NIBBLE_OUT <= 4'h0;
              TX_FRAME_ENABLE <= 1'b0;
            end
          end
          TX_PRE: begin
            TX_NIBBLE_OUT <= `PREAMBLE_NIBBLE;
            pre_cnt <= pre_cnt + 4'h1;
            if (pre_cnt == (`PREAMBLE_NIBBLES - 1))
              tx_state <= TX_SFD;
          end
          TX_SFD: begin
            TX_NIBBLE_OUT <= `SFD_NIBBLE;
            tx_state <= TX_DATA_ST;
          end
          TX_DATA_ST: begin
            if (TX_VALID) begin
              TX_NIBBLE_OUT <= TX_DATA;
              if (TX_LAST)
                tx_state <= TX_IDLE;
            end else begin
              TX_NIBBLE_OUT <= 4'h0;
              TX_FRAME_ENABLE <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  reg dv_d;
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      RX_DATA <= 4'h0;
      RX_STROBE <= 1'b0;
      RX_END <= 1'b0;
      dv_d <= 1'b0;
    end else if (CLK_EN) begin
      RX_STROBE <= 1'b0;
      RX_END <= 1'b0;
      if (rx_edge) begin
        dv_d <= dv_s[1];
        RX_END <= dv_d & ~dv_s[1];
        if (dv_s[1]) begin
          RX_DATA <= rxd_s2;
          RX_STROBE <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Management interface
  // ****************************************
  reg [7:0] div_cnt;
  reg mdc_int;
  reg [6:0] bit_cnt;
  reg [31:0] shift;
  reg active, is_read;
  wire own_clk = MGMT_CLOCK_LINE_OE;
  wire mdc_rise = own_clk ? (mdc_int == 1'b0 && div_cnt == MDC_HALF - 8'd1)
                          : (mdc_s[1] & ~mdc_d);
  wire mdc_fall = own_clk ? (mdc_int == 1'b1 && div_cnt == MDC_HALF - 8'd1)
                          : (~mdc_s[1] & mdc_d);
  assign MGMT_BUSY = active;
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      div_cnt <= 8'h00;
      mdc_int <= 1'b0;
      bit_cnt <= 7'd0;
      shift <= 32'h0;
      active <= 1'b0;
      is_read <= 1'b0;
      MGMT_RDATA <= 16'h0000;
      MGMT_DONE <= 1'b0;
      MGMT_CLOCK_LINE_OE <= 1'b0;
      MGMT_CLOCK_LINE_O <= 1'b0;
      MGMT_DATA_LINE_O <= 1'b1;
      MGMT_DATA_LINE_OE <= 1'b0;
    end else if (CLK_EN) begin
      MGMT_DONE <= 1'b0;
      MGMT_CLOCK_LINE_OE <= MGMT_CLOCK_DRIVE;
      if (div_cnt == MDC_HALF - 8'd1) begin
        div_cnt <= 8'h00;
        mdc_int <= ~mdc_int;
        // Pin moves with the toggle so data changes at the fall
        MGMT_CLOCK_LINE_O <= ~mdc_int;
      end else begin
        div_cnt <= div_cnt + 8'd1;
      end
      if (!active) begin
        if (MGMT_START) begin
          active <= 1'b1;
          is_read <= MGMT_READ;
          bit_cnt <= 7'd0;
          shift <= {`MGMT_START, MGMT_READ ? `MGMT_OP_READ : `MGMT_OP_WRITE,
                    MGMT_PHY_ADDR, MGMT_REG_ADDR, `MGMT_TA_WRITE, MGMT_WDATA};
        end
      end else if (mdc_fall) begin
        if (bit_cnt == (`MGMT_PREAMBLE_BITS + `MGMT_FRAME_BITS)) begin
          active <= 1'b0;
          MGMT_DONE <= 1'b1;
          MGMT_DATA_LINE_OE <= 1'b0;
          MGMT_DATA_LINE_O <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 7'd1;
          if (bit_cnt < `MGMT_PREAMBLE_BITS) begin
            MGMT_DATA_LINE_O <= 1'b1;
            MGMT_DATA_LINE_OE <= 1'b1;
          end else begin
            MGMT_DATA_LINE_O <= shift[31];
            shift <= {shift[30:0], 1'b0};
            MGMT_DATA_LINE_OE <= ~(is_read &&
              bit_cnt >= (`MGMT_PREAMBLE_BITS + 32 - `MGMT_TA_BIT - 1));
          end
        end
      end else if (mdc_rise && is_read && !MGMT_DATA_LINE_OE &&
                   bit_cnt > (`MGMT_PREAMBLE_BITS + 32 - 16)) begin
        MGMT_RDATA <= {MGMT_RDATA[14:0], mdi_s[1]};
      end
    end
  end

endmodule // mii_port_with_mgmt

/* testbench/mii_port_checker.sv */
// Purpose: Port timing checks
// Assumes: CLK_EN held high
// Notes: Bound to the top module
`timescale 1ns/1ps
module mii_port_checker (
  input wire SYS_CLK, // Clock
  input wire RESET, // Reset
  input wire PHY_TX_CLOCK_IN, // Tx clock pin
  input wire [3:0] TX_NIBBLE_OUT, // Tx nibble
  input wire TX_FRAME_ENABLE, // Tx enable
  input wire TX_READY, // Nibble taken
  input wire RX_VALID_IN, // Rx valid pin
  input wire RX_STROBE, // Rx strobe
  input wire COLLISION_IN, // Collision pin
  input wire COLLISION, // Synced collision
  input wire MGMT_CLOCK_DRIVE, // Clock drive select
  input wire MGMT_CLOCK_LINE_O, // Clock value
  input wire MGMT_CLOCK_LINE_OE, // Clock enable
  input wire MGMT_DATA_LINE_O, // Data value
  input wire MGMT_DATA_LINE_OE // Data enable
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  reg [3:0] idle;
  // Cycles since valid
  always @(posedge SYS_CLK)
    if (RESET || RX_VALID_IN) idle <= 4'h0;
    else if (idle != 4'hf) idle <= idle + 4'h1;
  a_reset_pins_idle: assert property ($fell(RESET) |-> !TX_FRAME_ENABLE &&
    !MGMT_CLOCK_LINE_OE && !MGMT_DATA_LINE_OE && MGMT_DATA_LINE_O) else $error("bad reset");
  a_clock_stays_input: assert property (!MGMT_CLOCK_DRIVE [*2] |-> !MGMT_CLOCK_LINE_OE)
    else $error("clock driven");
  a_preamble_first: assert property ($rose(TX_FRAME_ENABLE) |-> TX_NIBBLE_OUT == 4'h5)
    else $error("no preamble");
  a_ready_in_frame: assert property (TX_READY |-> $past(TX_FRAME_ENABLE, 64))
    else $error("early take");
  a_nibble_on_clock: assert property (!$stable(TX_NIBBLE_OUT) |-> $past(PHY_TX_CLOCK_IN))
    else $error("nibble off clock");
  a_strobe_needs_valid: assert property (RX_STROBE |-> idle < 4'h6)
    else $error("strobe without valid");
  a_collision_sync: assert property ($rose(COLLISION_IN) && !COLLISION |->
    !COLLISION [*3] ##1 COLLISION) else $error("bad sync");
  a_data_after_fall: assert property (MGMT_DATA_LINE_OE && MGMT_CLOCK_LINE_OE &&
    !$stable(MGMT_DATA_LINE_O) |-> !MGMT_CLOCK_LINE_O) else $error("data on rise");
endmodule // mii_port_checker
bind mii_port_with_mgmt mii_port_checker i_chk (.*);

/* testbench/phy_model.sv */
// Purpose: Transceiver model
// Assumes: Link clocks 160 ns, still when idle
// Notes: Released data line reads pull-up
`timescale 1ns/1ps
module phy_model (
  input wire run, // Clocks run
  input wire col, // Collision request
  input wire rx_on, // Send nibbles
  output reg tx_clk, // Tx clock
  output reg rx_clk, // Rx clock
  output reg [3:0] rx_nib = 4'h0, // Rx nibble
  output reg rx_dv = 1'b0, // Rx valid
  output wire col_o, // Collision pin
  output wire crs, // Carrier pin
  input wire d_oe, // Device drives data
  input wire d_o, // Device data
  output wire d_line // Data line
);
  initial begin
    {tx_clk, rx_clk} = 2'b00;
    #33;
    forever begin
      #80;
      tx_clk = run & ~tx_clk;
      rx_clk = run & ~rx_clk;
    end
  end
  always @(negedge rx_clk) begin
    rx_dv <= rx_on;
    rx_nib <= rx_on ? rx_nib + 4'h1 : ~rx_nib;
  end
  assign col_o = col;
  assign crs = col | rx_dv;
  assign d_line = d_oe ? d_o : 1'b1;
endmodule // phy_model

/* testbench/tb_top.sv */
// Purpose: Self-checking bench
// Assumes: 50 MHz clock
// Notes: Management clock pin resolved here
`timescale 1ns/1ps
module tb_top;
  reg SYS_CLK = 0, RESET = 1, run = 0, col = 0, rx_on = 0, prev;
  wire CLK_EN = 1'b1;
  reg [3:0] TX_DATA = 4'h1, nib;
  reg TX_VALID = 0, TX_LAST = 0, MGMT_CLOCK_DRIVE = 0, MGMT_START = 0, MGMT_READ = 0;
  reg [4:0] MGMT_PHY_ADDR = 5'h11, MGMT_REG_ADDR = 5'h0a;
  reg [15:0] MGMT_WDATA = 16'hc3a5;
  wire PHY_TX_CLOCK_IN, PHY_RX_CLOCK_IN, RX_VALID_IN, COLLISION_IN, CARRIER_SENSE_IN;
  wire [3:0] RX_NIBBLE_IN, TX_NIBBLE_OUT, RX_DATA;
  wire TX_READY, TX_FRAME_ENABLE, RX_STROBE, RX_END, COLLISION, CARRIER, MGMT_BUSY, MGMT_DONE;
  wire [15:0] MGMT_RDATA;
  wire MGMT_CLOCK_LINE_O, MGMT_CLOCK_LINE_OE, MGMT_DATA_LINE_I, MGMT_DATA_LINE_O;
  wire MGMT_DATA_LINE_OE;
  reg mdc_run = 0, ext_mdc = 0;
  reg [3:0] mdc_div = 4'h0;
  wire MGMT_CLOCK_LINE_I = MGMT_CLOCK_LINE_OE ? MGMT_CLOCK_LINE_O : ext_mdc;
  always @(posedge SYS_CLK)
    if (mdc_run) begin
      mdc_div <= (mdc_div == 4'h9) ? 4'h0 : mdc_div + 4'h1;
      if (mdc_div == 4'h9) ext_mdc <= ~ext_mdc;
    end
  integer mismatches = 0, cmp_count = 0, k, n;
  reg [63:0] got, exp;
  mii_port_with_mgmt i_dut (.*);
  phy_model i_phy (.run(run), .col(col), .rx_on(rx_on), .tx_clk(PHY_TX_CLOCK_IN),
    .rx_clk(PHY_RX_CLOCK_IN), .rx_nib(RX_NIBBLE_IN), .rx_dv(RX_VALID_IN),
    .col_o(COLLISION_IN), .crs(CARRIER_SENSE_IN), .d_oe(MGMT_DATA_LINE_OE),
    .d_o(MGMT_DATA_LINE_O), .d_line(MGMT_DATA_LINE_I));
  initial forever #10 SYS_CLK = ~SYS_CLK;
  task chk(input [63:0] g, input [63:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task t_tx;
    begin
      k = 0;
      prev = 0;
      run <= 1;
      TX_VALID <= 1;
      for (n = 0; n < 400 && k < 20; n = n + 1) begin
        @(posedge SYS_CLK);
        if (TX_READY) begin
          TX_DATA <= TX_DATA + 4'h1;
          TX_LAST <= TX_DATA == 4'h2;
          if (TX_LAST) TX_VALID <= 0;
        end
        if (prev && !PHY_TX_CLOCK_IN && (k > 0 || TX_FRAME_ENABLE)) begin
          if (k < 19) chk({TX_FRAME_ENABLE, TX_NIBBLE_OUT}, k < 15 ? 5'h15 : k == 15 ? 5'h1d : k + 1);
          else chk(TX_FRAME_ENABLE, 0);
          k = k + 1;
        end
        prev = PHY_TX_CLOCK_IN;
      end
      chk(k, 20);
    end
  endtask
  task t_rx;
    begin
      k = 0;
      rx_on <= 1;
      repeat (48) begin
        @(posedge SYS_CLK);
        if (RX_STROBE && k > 0) chk(RX_DATA, {nib + 4'h1});
        if (RX_STROBE) {k, nib} = {k + 1, RX_DATA};
      end
      chk(k > 3, 1);
      rx_on <= 0;
      n = 0;
      repeat (40) @(posedge SYS_CLK) n = n + RX_END;
      chk(n, 1);
      run <= 0;
    end
  endtask
  task t_col;
    begin
      col <= 1;
      repeat (6) @(posedge SYS_CLK);
      chk({COLLISION, CARRIER}, 2'b11);
      col <= 0;
      repeat (6) @(posedge SYS_CLK);
      chk({COLLISION, CARRIER}, 2'b00);
    end
  endtask
  task t_mgmt(input rd);
    begin
      exp = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, MGMT_PHY_ADDR, MGMT_REG_ADDR,
        rd ? 18'h3ffff : {2'b10, MGMT_WDATA}};
      MGMT_READ <= rd;
      MGMT_START <= 1;
      @(posedge SYS_CLK);
      MGMT_START <= 0;
      {prev, n} = 0;
      while (!MGMT_DONE && n < 2000) begin
        @(posedge SYS_CLK);
        n = n + 1;
        if (n == 1) chk(MGMT_BUSY, 1);
        if (!prev && MGMT_CLOCK_LINE_I) got = {got[62:0], MGMT_DATA_LINE_I};
        prev = MGMT_CLOCK_LINE_I;
      end
      chk(n < 2000, 1);
      chk(MGMT_BUSY, 0);
      chk(got | (rd ? 64'h20000 : 64'h0), exp);
      if (rd) chk(MGMT_RDATA, 16'hffff);
    end
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RESET <= 0;
    @(posedge SYS_CLK);
    chk({TX_FRAME_ENABLE, MGMT_CLOCK_LINE_OE, MGMT_DATA_LINE_OE, MGMT_DATA_LINE_O}, 1);
    t_tx;
    t_rx;
    t_col;
    mdc_run <= 1;
    t_mgmt(0);
    mdc_run <= 0;
    MGMT_CLOCK_DRIVE <= 1;
    repeat (3) @(posedge SYS_CLK);
    chk(MGMT_CLOCK_LINE_OE, 1);
    t_mgmt(0);
    t_mgmt(1);
    results;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    results;
  end
endmodule // tb_top
